//--- hw/fmc_pkg.sv
// Functional notes
// - fuse operations only in test or fuse mode
// - emulated mirror lost on supply, deep fail-safe, standby; kept while no sector is burned yet
// - two fuse blocks, each with two sectors
// - start-up loads last valid sector into mirror
// - host reads/writes mirror through dedicated commands
// - burn writes mirror into next unused sector
// - first burn first sector, second burn second
// - never fall back to an earlier sector
// - no burn after second sector; emulation stays
// - user mode blocks mirror and fuse access
// - fuse mode entry loads fuses, allows burn, emulation
// - test mode grants burn and mirror access
// - normal mode windowing and timeout from fuses
// - debug mode: no windowing, timeout, safety reactions
// - debug pin at start-up enters debug and fuse
// - fuse mode always implies debug mode
// - commands leave debug mode and fuse mode
// - test mode command accepted only with debug pin
// - infinite bit 0: windowing on, 2 s timeout
// - infinite bit 1: windowing off, no timeout
// - regulators off while in fuse mode
// - power-up on pin removal or fuse exit command
// - after fuse exit start regulators, init state
// - fault output held until debug exit bit written
package fmc_pkg;
    localparam int FMC_DATA_W = 16;
    localparam int FMC_ADDR_W = 3;
    localparam int FMC_DEPTH = 8;
    localparam int FMC_CLK_HZ = 25000000;
    localparam int FMC_INIT_TMO_S = 2;
    localparam int FMC_INIT_TMO_CYC = FMC_INIT_TMO_S * FMC_CLK_HZ;
    localparam int FMC_CNT_W = 26;
    localparam int FMC_WIN_OFF_BIT = 0;
    localparam logic [1:0] FMC_SECT_RST = 2'h0;

    typedef enum logic [2:0] {
        FMC_ST_START = 3'h0,
        FMC_ST_LOAD = 3'h1,
        FMC_ST_FUSE = 3'h2,
        FMC_ST_INIT = 3'h3,
        FMC_ST_RUN = 3'h4,
        FMC_ST_BURN = 3'h5
    } fmc_state_e;

    function automatic logic [1:0] fmc_next_used(input logic [1:0] used);
        fmc_next_used = {used[0] | used[1], 1'b1};
    endfunction
endpackage

//--- hw/fmc_mem.sv
`timescale 1ns/10ps
module fmc_mem import fmc_pkg::*; (
    input wire logic clock, // system clock
    input wire logic we, // write strobe
    input wire logic [FMC_ADDR_W-1:0] waddr, // write word
    input wire logic [FMC_DATA_W-1:0] wdata, // write data
    input wire logic [FMC_ADDR_W-1:0] raddr, // read word
    output logic [FMC_DATA_W-1:0] rdata // registered read data
);
    logic [FMC_DATA_W-1:0] mem [FMC_DEPTH];

    always_ff @(posedge clock) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule

//--- hw/fmc_top.sv
`timescale 1ns/10ps
module fmc_top import fmc_pkg::*; #(
    parameter int INIT_TMO_CYC = FMC_INIT_TMO_CYC // init timeout in cycles
) (
    input wire logic clock, // 25 MHz system clock
    input wire logic sys_rst, // synchronous reset, power-on or restart
    input wire logic debug_mode_pin, // debug pin level, asynchronous
    input wire logic power_lost, // supply removed
    input wire logic deep_fail_safe_state, // deep fail-safe entered
    input wire logic standby, // standby entered
    input wire logic mir_wr, // host mirror write command
    input wire logic mir_rd, // host mirror read command
    input wire logic mir_blk, // 0 main block, 1 fail-safe block
    input wire logic [FMC_ADDR_W-1:0] mir_addr, // mirror word
    input wire logic [FMC_DATA_W-1:0] mir_wdata, // mirror write data
    output logic [FMC_DATA_W-1:0] mir_rdata, // mirror read data
    output logic mir_rvalid, // read data valid pulse
    output logic cmd_refused, // command refused pulse
    input wire logic burn_cmd, // burn mirror to next sector
    input wire logic fuse_exit_cmd, // leave fuse mode
    input wire logic debug_exit_cmd, // leave debug mode
    input wire logic test_mode_cmd, // enter test mode
    input wire logic debug_mode_exit_bit, // write of 1 to exit bit
    input wire logic fail_safe_fault, // fail-safe fault event
    output logic burn_busy, // burn in progress
    output logic [1:0] main_used, // main sectors used
    output logic [1:0] fs_used, // fail-safe sectors used
    output logic fuse_mode, // fuse mode active
    output logic debug_mode, // debug mode active
    output logic test_mode, // test mode active
    output logic regulators_on, // regulators enabled
    output logic fail_safe_init_state, // fail-safe in init state
    output logic wd_window_en, // watchdog windowing enabled
    output logic init_timeout, // init timeout expired
    output logic safety_fault_output_n // safety fault, low asserted
);
    // ----------------------------------------
    // pin synchroniser
    // ----------------------------------------
    logic pin_meta_q, pin_sync_q;
    always_ff @(posedge clock) begin
        pin_meta_q <= debug_mode_pin;
        pin_sync_q <= pin_meta_q;
    end

    // ----------------------------------------
    // fuse arrays and mirror memories
    // ----------------------------------------
    fmc_state_e state_q, state_d;
    logic [FMC_ADDR_W-1:0] idx_q;
    // used flags model fuse state, so no restart or reset clears them
    logic [1:0] main_used_q = FMC_SECT_RST;
    logic [1:0] fs_used_q = FMC_SECT_RST;
    logic [FMC_DATA_W-1:0] fuse_q [2][2][FMC_DEPTH]; // block, sector, word
    logic mir_valid_q;
    logic fuse_mode_q, debug_mode_q, test_mode_q;
    logic fault_hold_q;
    logic rd_pend_q;

    // active sector: the second once burned, never back to the first
    function automatic logic sect_pick(input logic [1:0] used);
        sect_pick = used[1];
    endfunction

    wire fuse_ok = fuse_mode_q | test_mode_q;
    wire main_sel = sect_pick(main_used_q);
    wire fs_sel = sect_pick(fs_used_q);
    wire loading = state_q == FMC_ST_LOAD;
    wire burning = state_q == FMC_ST_BURN;
    wire host_wr = mir_wr & fuse_ok & ~loading & ~burning;
    wire host_rd = mir_rd & fuse_ok & ~loading & ~burning;
    wire [FMC_DATA_W-1:0] m_ld = fuse_q[0][main_sel][idx_q];
    wire [FMC_DATA_W-1:0] f_ld = fuse_q[1][fs_sel][idx_q];
    wire m_we = (loading & main_used_q != 2'h0) | (host_wr & ~mir_blk);
    wire f_we = (loading & fs_used_q != 2'h0) | (host_wr & mir_blk);
    wire [FMC_ADDR_W-1:0] waddr = loading ? idx_q : mir_addr;
    wire [FMC_ADDR_W-1:0] raddr = burning ? idx_q : mir_addr;
    wire [FMC_DATA_W-1:0] m_wd = loading ? m_ld : mir_wdata;
    wire [FMC_DATA_W-1:0] f_wd = loading ? f_ld : mir_wdata;
    logic [FMC_DATA_W-1:0] m_rd, f_rd;

    fmc_mem u_main_mir (
        .clock(clock),
        .we(m_we),
        .waddr(waddr),
        .wdata(m_wd),
        .raddr(raddr),
        .rdata(m_rd)
    );
    fmc_mem u_fs_mir (
        .clock(clock),
        .we(f_we),
        .waddr(waddr),
        .wdata(f_wd),
        .raddr(raddr),
        .rdata(f_rd)
    );

    // ----------------------------------------
    // mode control
    // ----------------------------------------
    logic rd_blk_q;
    logic [FMC_CNT_W-1:0] tmo_cnt_q;
    logic tmo_q;
    logic burn_go_q;
    logic win_off_q;

    wire mirror_loss = power_lost | deep_fail_safe_state | standby;
    wire full = main_used_q[1] & fs_used_q[1];
    wire burn_ok = burn_cmd & fuse_ok & ~full & state_q != FMC_ST_BURN
        & state_q != FMC_ST_LOAD;
    wire pin_gone = fuse_mode_q & ~pin_sync_q;
    wire fuse_leave = state_q == FMC_ST_FUSE & (fuse_exit_cmd | pin_gone);
    wire last_idx = idx_q == FMC_ADDR_W'(FMC_DEPTH - 1);

    always_comb begin
        state_d = state_q;
        case (state_q)
            FMC_ST_START: begin
                state_d = FMC_ST_LOAD;
            end
            FMC_ST_LOAD: begin
                if (last_idx) begin
                    state_d = fuse_mode_q ? FMC_ST_FUSE : FMC_ST_INIT;
                end
            end
            FMC_ST_FUSE: begin
                if (burn_ok) begin
                    state_d = FMC_ST_BURN;
                end else if (fuse_leave) begin
                    state_d = FMC_ST_INIT;
                end
            end
            FMC_ST_INIT: begin
                if (burn_ok) begin
                    state_d = FMC_ST_BURN;
                end else if (debug_mode_exit_bit) begin
                    state_d = FMC_ST_RUN;
                end
            end
            FMC_ST_RUN: begin
                if (burn_ok) begin
                    state_d = FMC_ST_BURN;
                end
            end
            FMC_ST_BURN: begin
                if (burn_go_q) begin
                    state_d = fuse_mode_q ? FMC_ST_FUSE : FMC_ST_INIT;
                end
            end
            default: begin
                state_d = FMC_ST_START;
            end
        endcase
        // any loss of the emulated image restarts the load
        if (mirror_loss) begin
            state_d = FMC_ST_START;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_q <= FMC_ST_START;
            fuse_mode_q <= 1'b0;
            debug_mode_q <= 1'b0;
            test_mode_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (state_q == FMC_ST_START) begin
                fuse_mode_q <= pin_sync_q;
                debug_mode_q <= pin_sync_q;
            end else begin
                if (fuse_leave) begin
                    fuse_mode_q <= 1'b0;
                end
                if (debug_exit_cmd & ~fuse_mode_q) begin
                    debug_mode_q <= 1'b0;
                end else if (fuse_mode_q) begin
                    debug_mode_q <= 1'b1;
                end
                if (test_mode_cmd & pin_sync_q) begin
                    test_mode_q <= 1'b1;
                end
            end
        end
    end

    // ----------------------------------------
    // load and burn sequencing
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            idx_q <= '0;
            burn_go_q <= 1'b0;
            win_off_q <= 1'b0;
            mir_valid_q <= 1'b0;
        end else begin
            burn_go_q <= burning & last_idx;
            if (state_q == FMC_ST_START | burn_ok) begin
                idx_q <= '0;
            end else if (loading | (burning & ~burn_go_q)) begin
                idx_q <= idx_q + 1'b1;
            end
            if (loading & idx_q == '0) begin
                win_off_q <= fuse_q[1][fs_sel][0][FMC_WIN_OFF_BIT];
            end
            // no word is written once the used flags have moved on
            mir_valid_q <= burning & ~burn_go_q;
        end
    end

    // ----------------------------------------
    // sector bookkeeping
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (burn_go_q) begin
            if (!main_used_q[1]) begin
                main_used_q <= fmc_next_used(main_used_q);
            end
            if (!fs_used_q[1]) begin
                fs_used_q <= fmc_next_used(fs_used_q);
            end
        end
    end

    // read data of the burn walk lags the index by one cycle
    logic [FMC_ADDR_W-1:0] bidx_q;
    always_ff @(posedge clock) begin
        bidx_q <= idx_q;
        if (mir_valid_q) begin
            if (!main_used_q[1]) begin
                fuse_q[0][main_used_q[0]][bidx_q] <= m_rd;
            end
            if (!fs_used_q[1]) begin
                fuse_q[1][fs_used_q[0]][bidx_q] <= f_rd;
            end
        end
    end

    // ----------------------------------------
    // host read, timeout and fault
    // ----------------------------------------
    wire tmo_run = ~debug_mode_q & ~win_off_q;
    wire tmo_end = tmo_cnt_q >= FMC_CNT_W'(INIT_TMO_CYC - 1);

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rd_pend_q <= 1'b0;
            rd_blk_q <= 1'b0;
            mir_rdata <= '0;
            mir_rvalid <= 1'b0;
            cmd_refused <= 1'b0;
            tmo_cnt_q <= '0;
            tmo_q <= 1'b0;
            fault_hold_q <= 1'b1;
        end else begin
            rd_pend_q <= host_rd;
            rd_blk_q <= mir_blk;
            mir_rvalid <= rd_pend_q;
            if (rd_pend_q) begin
                mir_rdata <= rd_blk_q ? f_rd : m_rd;
            end
            // accesses dropped during a load or burn walk are not flagged
            cmd_refused <= (mir_wr | mir_rd | burn_cmd) & ~fuse_ok
                | burn_cmd & full;
            if (state_q != FMC_ST_INIT) begin
                tmo_cnt_q <= '0;
                tmo_q <= 1'b0;
            end else if (tmo_run) begin
                if (tmo_end) begin
                    tmo_q <= 1'b1;
                end else begin
                    tmo_cnt_q <= tmo_cnt_q + 1'b1;
                end
            end
            // fault is held from every start-up until the exit bit
            if (state_q == FMC_ST_START) begin
                fault_hold_q <= 1'b1;
            end else if (debug_mode_exit_bit) begin
                fault_hold_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    wire safety_react = ~debug_mode_q & (fail_safe_fault | tmo_q);
    assign safety_fault_output_n = ~(fault_hold_q | safety_react);
    assign burn_busy = burning;
    assign main_used = main_used_q;
    assign fs_used = fs_used_q;
    assign fuse_mode = fuse_mode_q;
    assign debug_mode = debug_mode_q;
    assign test_mode = test_mode_q;
    // regulators stay off through start, load and fuse mode
    assign regulators_on = state_q == FMC_ST_INIT | state_q == FMC_ST_RUN
        | (burning & ~fuse_mode_q);
    assign fail_safe_init_state = state_q == FMC_ST_INIT;
    assign wd_window_en = tmo_run;
    assign init_timeout = tmo_q;
endmodule

//--- dv/fmc_monitor.sv
`timescale 1ns/10ps
module fmc_monitor import fmc_pkg::*; (
    input wire logic clock, // clk
    input wire logic sys_rst, // rst
    input wire logic mir_rd, // rd
    input wire logic test_mode_cmd, // test
    input wire logic burn_cmd, // burn
    input wire logic debug_mode_exit_bit, // exit bit
    input wire logic cmd_refused, // refused
    input wire logic mir_rvalid, // rvalid
    input wire logic burn_busy, // busy
    input wire logic [1:0] main_used, // used
    input wire logic fuse_mode, // fuse
    input wire logic debug_mode, // debug
    input wire logic test_mode, // test
    input wire logic regulators_on, // regs
    input wire logic wd_window_en, // window
    input wire logic safety_fault_output_n // fault
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    logic exit_seen_q;
    always_ff @(posedge clock) begin
        exit_seen_q <= !sys_rst && (exit_seen_q || debug_mode_exit_bit);
    end
    // ------------------------------------------------
    // port checks
    // ------------------------------------------------
    property p_fuse_debug; fuse_mode |-> debug_mode; endproperty
    a_fuse_debug: assert property (p_fuse_debug) else $error("fuse without debug");
    property p_fuse_regs; fuse_mode |-> !regulators_on; endproperty
    a_fuse_regs: assert property (p_fuse_regs) else $error("regulator on in fuse");
    property p_user_ref; mir_rd && regulators_on && !fuse_mode && !test_mode |=> cmd_refused; endproperty
    a_user_ref: assert property (p_user_ref) else $error("user read not refused");
    property p_rd_priv; mir_rvalid |-> $past(fuse_mode || test_mode, 2); endproperty
    a_rd_priv: assert property (p_rd_priv) else $error("read outside fuse or test");
    property p_burn_len; $rose(burn_busy) |-> burn_busy [*8] ##[1:3] !burn_busy; endproperty
    a_burn_len: assert property (p_burn_len) else $error("burn length wrong");
    property p_sect1; $rose(burn_busy) && main_used == 2'h0 |-> ##[1:12] main_used == 2'h1; endproperty
    a_sect1: assert property (p_sect1) else $error("first burn sector wrong");
    property p_sect2; $rose(burn_busy) && main_used == 2'h1 |-> ##[1:12] main_used == 2'h3; endproperty
    a_sect2: assert property (p_sect2) else $error("second burn sector wrong");
    property p_full; burn_cmd && main_used == 2'h3 && fuse_mode && !burn_busy |=> cmd_refused; endproperty
    a_full: assert property (p_full) else $error("burn when full not refused");
    property p_debug_win; debug_mode |-> !wd_window_en; endproperty
    a_debug_win: assert property (p_debug_win) else $error("windowing in debug");
    property p_fault; safety_fault_output_n |-> exit_seen_q; endproperty
    a_fault: assert property (p_fault) else $error("fault released early");
    property p_test; $rose(test_mode) |-> $past(test_mode_cmd); endproperty
    a_test: assert property (p_test) else $error("test mode without command");
    c_exit: cover property (fuse_mode ##1 !fuse_mode);
    c_full: cover property (burn_cmd && main_used == 2'h3 ##1 cmd_refused);
    c_test: cover property ($rose(test_mode));
endmodule

bind fmc_top fmc_monitor u_mon (.*);

//--- dv/fmc_host_model.sv
`timescale 1ns/10ps
module fmc_host_model import fmc_pkg::*; (
    input wire logic clock, // clk
    output logic debug_mode_pin, // pin
    output logic mir_wr, // wr
    output logic mir_rd, // rd
    output logic mir_blk, // block
    output logic [FMC_ADDR_W-1:0] mir_addr, // word
    output logic [FMC_DATA_W-1:0] mir_wdata, // wdata
    input wire logic [FMC_DATA_W-1:0] mir_rdata, // rdata
    input wire logic mir_rvalid, // rvalid
    input wire logic cmd_refused, // refused
    input wire logic burn_busy, // busy
    output logic burn_cmd, // burn
    output logic fuse_exit_cmd, // fuse exit
    output logic debug_exit_cmd, // debug exit
    output logic test_mode_cmd, // test
    output logic debug_mode_exit_bit // exit bit
);
    logic [4:0] pulse_q;
    assign {burn_cmd, fuse_exit_cmd, debug_exit_cmd, test_mode_cmd, debug_mode_exit_bit} = pulse_q;
    initial begin
        {debug_mode_pin, mir_wr, mir_rd, mir_blk, pulse_q, mir_addr, mir_wdata} = '0;
    end
    task automatic set_pin(input logic v);
        @(posedge clock);
        debug_mode_pin <= v;
    endtask
    task automatic send(input logic [4:0] c);
        @(posedge clock);
        pulse_q <= c;
        @(posedge clock);
        pulse_q <= 5'h0;
    endtask
    // idle address and data lines show the inverse of the last value
    task automatic xfer(input logic w, input logic b, input logic [FMC_ADDR_W-1:0] a,
            input logic [FMC_DATA_W-1:0] d, output logic [FMC_DATA_W-1:0] q,
            output logic [1:0] st);
        @(posedge clock);
        {mir_wr, mir_rd, mir_blk, mir_addr, mir_wdata} <= {w, !w, b, a, d};
        @(posedge clock);
        {mir_wr, mir_rd, mir_addr, mir_wdata} <= {2'h0, ~a, ~d};
        {st, q} = '0;
        for (int n = 0; n < 6; n++) begin
            @(posedge clock);
            if (mir_rvalid) q = mir_rdata;
            st = st | {cmd_refused, mir_rvalid};
        end
    endtask
    task automatic burn(output logic refused);
        send(5'h10);
        refused = 1'b0;
        for (int n = 0; n < 20; n++) begin
            @(posedge clock);
            refused = refused | cmd_refused;
            if (n > 2 && !burn_busy) break;
        end
        @(posedge clock);
    endtask
endmodule

//--- dv/fuse_mirror_mode_control_tb_top.sv
`timescale 1ns/10ps
module fuse_mirror_mode_control_tb_top import fmc_pkg::*; ;
    localparam logic [4:0] FEXIT = 5'h08;
    localparam logic [4:0] DEXIT = 5'h04;
    localparam logic [4:0] TEST = 5'h02;
    localparam logic [4:0] XBIT = 5'h01;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic power_lost = 1'b0;
    logic deep_fail_safe_state = 1'b0;
    logic standby = 1'b0;
    logic fail_safe_fault = 1'b0;
    wire debug_mode_pin, mir_wr, mir_rd, mir_blk, mir_rvalid, cmd_refused, burn_cmd;
    wire fuse_exit_cmd, debug_exit_cmd, test_mode_cmd, debug_mode_exit_bit, burn_busy;
    wire fuse_mode, debug_mode, test_mode, regulators_on, fail_safe_init_state;
    wire wd_window_en, init_timeout, safety_fault_output_n;
    wire [FMC_ADDR_W-1:0] mir_addr;
    wire [FMC_DATA_W-1:0] mir_wdata, mir_rdata;
    wire [1:0] main_used, fs_used;
    int n_mismatch = 0;
    int samples_checked = 0;
    logic [FMC_DATA_W-1:0] q;
    logic [1:0] st;
    logic rf;
    fmc_top #(.INIT_TMO_CYC(20)) dut (.*);
    fmc_host_model u_host (.*);
    always #20 clock = ~clock;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // src 0..3 selects sys_rst, power_lost, deep fail-safe, standby
    task automatic restart(input logic [1:0] src, input logic pin);
        u_host.set_pin(pin);
        @(posedge clock);
        {standby, deep_fail_safe_state, power_lost, sys_rst} <= 4'h1 << src;
        repeat (8) @(posedge clock);
        {standby, deep_fail_safe_state, power_lost, sys_rst} <= 4'h0;
        repeat (12) @(posedge clock);
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        restart(2'h0, 1'b1);
        chk(16'({fuse_mode, debug_mode, regulators_on}), 16'h6, "pin start");
        u_host.xfer(1'b1, 1'b0, 3'h0, 16'ha1a1, q, st);
        u_host.xfer(1'b1, 1'b1, 3'h0, 16'h0001, q, st);
        u_host.xfer(1'b0, 1'b0, 3'h0, 16'h0, q, st);
        chk(q, 16'ha1a1, "readback");
        u_host.burn(rf);
        chk(16'({rf, main_used, fs_used}), 16'h5, "burn 1");
        restart(2'h0, 1'b0);
        chk(16'({fuse_mode, debug_mode, regulators_on, wd_window_en}), 16'h2, "user");
        repeat (30) @(posedge clock);
        chk(16'(init_timeout), 16'h0, "no timeout");
        u_host.xfer(1'b0, 1'b0, 3'h0, 16'h0, q, st);
        chk(16'(st), 16'h2, "user read");
        u_host.send(TEST);
        @(posedge clock);
        chk(16'(test_mode), 16'h0, "test without pin");
        restart(2'h0, 1'b1);
        u_host.xfer(1'b0, 1'b0, 3'h0, 16'h0, q, st);
        chk(q, 16'ha1a1, "load 1");
        u_host.xfer(1'b0, 1'b1, 3'h0, 16'h0, q, st);
        chk(q, 16'h0001, "fail-safe load 1");
        u_host.xfer(1'b1, 1'b0, 3'h0, 16'hb2b2, q, st);
        u_host.xfer(1'b1, 1'b1, 3'h0, 16'h0000, q, st);
        u_host.burn(rf);
        chk(16'({rf, main_used, fs_used}), 16'hf, "burn 2");
        u_host.burn(rf);
        chk(16'({rf, main_used, fs_used}), 16'h1f, "burn 3");
        u_host.send(FEXIT);
        repeat (2) @(posedge clock);
        chk(16'({fuse_mode, debug_mode, regulators_on, fail_safe_init_state, wd_window_en,
            safety_fault_output_n}), 16'h1c, "fuse exit");
        u_host.send(XBIT);
        repeat (2) @(posedge clock);
        chk(16'(safety_fault_output_n), 16'h1, "release");
        fail_safe_fault <= 1'b1;
        repeat (3) @(posedge clock);
        chk(16'(safety_fault_output_n), 16'h1, "debug fault");
        u_host.send(DEXIT);
        repeat (3) @(posedge clock);
        chk(16'({debug_mode, safety_fault_output_n}), 16'h0, "debug exit");
        fail_safe_fault <= 1'b0;
        restart(2'h0, 1'b0);
        chk(16'({debug_mode, wd_window_en, init_timeout}), 16'h2, "normal");
        repeat (30) @(posedge clock);
        chk(16'({init_timeout, safety_fault_output_n}), 16'h2, "timeout");
        u_host.set_pin(1'b1);
        repeat (4) @(posedge clock);
        u_host.send(TEST);
        @(posedge clock);
        chk(16'({test_mode, fuse_mode, debug_mode}), 16'h4, "test");
        u_host.xfer(1'b0, 1'b0, 3'h0, 16'h0, q, st);
        chk(q, 16'hb2b2, "load 2");
        for (int s = 1; s < 4; s++) begin
            u_host.xfer(1'b1, 1'b0, 3'h0, 16'hc3c3, q, st);
            u_host.xfer(1'b0, 1'b0, 3'h0, 16'h0, q, st);
            chk(q, 16'hc3c3, "emulate");
            restart(2'(s), 1'b1);
            u_host.xfer(1'b0, 1'b0, 3'h0, 16'h0, q, st);
            chk(q, 16'hb2b2, "emulation lost");
        end
        conclude();
    end
    initial begin
        repeat (5000) @(posedge clock);
        n_mismatch++;
        $display("MISMATCH %0t run did not finish", $time);
        conclude();
    end
endmodule
